// >>> hw/ssem_pkg.sv
package ssem_pkg;
  // Source indices inside the mask / store / event vectors
  localparam int SRC_VECTOR = 0;
  localparam int SRC_ADC    = 1;
  localparam int SRC_OFFSET = 2;
  localparam int SRC_GAIN   = 3;
  localparam int SRC_SPEED  = 4;
  localparam int SRC_ABZ    = 5;
  localparam int SRC_NONIUS = 6;
  localparam int NUM_SRC    = 7;
  // Stream status bit positions
  localparam int STREAM_WARN_BIT  = 0;
  localparam int STREAM_ERROR_BIT = 1;
  localparam int STREAM_WIDTH     = 2;
  // Vector threshold in percent of nominal amplitude
  localparam int VECTOR_MIN_PERCENT = 30;
  localparam int PERCENT_FULL       = 100;
  // Flag positions inside the per-flag vectors
  localparam int NUM_FLAG           = 10;
  localparam int FLAG_VECTOR        = 0;
  localparam int FLAG_SINE_ADC      = 1;
  localparam int FLAG_COSINE_ADC    = 2;
  localparam int FLAG_SINE_OFFSET   = 3;
  localparam int FLAG_COSINE_OFFSET = 4;
  localparam int FLAG_SINE_GAIN     = 5;
  localparam int FLAG_COSINE_GAIN   = 6;
  localparam int FLAG_SPEED         = 7;
  localparam int FLAG_ABZ           = 8;
  localparam int FLAG_NONIUS        = 9;
  // Reset values; all sources enabled
  localparam logic [9:0] FLAGS_RESET = 10'h000;
  localparam logic [6:0] FLAGS_ALL   = 7'h7F;
endpackage

// >>> hw/ssem_monitor.sv
`timescale 1ns/1ps
module ssem_monitor
  import ssem_pkg::*;
#(
  parameter int AMP_WIDTH = 16
) (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Live sensor conditions
  input  wire logic [AMP_WIDTH-1:0] vector_magnitude,
  input  wire logic [AMP_WIDTH-1:0] nominal_amplitude,
  input  wire logic                 sine_adc_over,
  input  wire logic                 cosine_adc_over,
  input  wire logic                 sine_offset_limit,
  input  wire logic                 cosine_offset_limit,
  input  wire logic                 sine_gain_limit,
  input  wire logic                 cosine_gain_limit,
  input  wire logic                 speed_fault,
  input  wire logic                 abz_fault,
  input  wire logic                 nonius_fault,
  input  wire logic                 rate_setting_changed,
  // Configuration, one mask and one store bit per source, then the two fault actions
  input  wire logic                 vector_mask,
  input  wire logic                 adc_mask,
  input  wire logic                 offset_mask,
  input  wire logic                 gain_mask,
  input  wire logic                 speed_mask,
  input  wire logic                 abz_mask,
  input  wire logic                 nonius_mask,
  input  wire logic                 vector_store,
  input  wire logic                 adc_store,
  input  wire logic                 offset_store,
  input  wire logic                 gain_store,
  input  wire logic                 speed_store,
  input  wire logic                 abz_store,
  input  wire logic                 nonius_store,
  input  wire logic                 hold_on_fault,
  input  wire logic                 tristate_on_fault,
  // Clearing of latched flags
  input  wire logic                 counter_reset_command,
  input  wire logic                 preset_pulse,
  // Status outputs
  output logic                      vector_flag,
  output logic                      sine_adc_flag,
  output logic                      cosine_adc_flag,
  output logic                      sine_offset_flag,
  output logic                      cosine_offset_flag,
  output logic                      sine_gain_flag,
  output logic                      cosine_gain_flag,
  output logic                      speed_flag,
  output logic                      abz_flag,
  output logic                      nonius_flag,
  output logic                      status_error,
  output logic                      position_error,
  output logic [STREAM_WIDTH-1:0]   stream_status_bits,
  output logic                      error_pin_n,
  output logic                      error_pin_n_oe,
  output logic                      abz_hold,
  output logic                      abz_tristate
);

  // Flag order: vec, sadc, cadc, soff, coff, sgain, cgain, speed, abz, nonius;
  // ten flags from seven sources, since three sources report per channel
  localparam int NFLAG = NUM_FLAG;

  logic [NFLAG-1:0] live;
  logic [NFLAG-1:0] gate;
  logic [NFLAG-1:0] keep;
  logic [NFLAG-1:0] flag;
  logic [NFLAG-1:0] next_flag;
  logic [STREAM_WIDTH-1:0] next_stream;
  logic             next_any;
  logic             any_fault;
  logic             next_hold;
  logic             next_tri;
  logic             vector_low;

  // Compare scaled values; widened to avoid overflow of the product
  function automatic logic below_percent(input logic [AMP_WIDTH-1:0] value,
                                         input logic [AMP_WIDTH-1:0] nominal);
    logic [AMP_WIDTH+7:0] lhs;
    logic [AMP_WIDTH+7:0] rhs;
    lhs = (AMP_WIDTH+8)'(value) * (AMP_WIDTH+8)'(PERCENT_FULL);
    rhs = (AMP_WIDTH+8)'(nominal) * (AMP_WIDTH+8)'(VECTOR_MIN_PERCENT);
    return lhs < rhs;
  endfunction

  // Vector test on the live magnitude; one noisy sample is enough to raise it
  assign vector_low = below_percent(vector_magnitude, nominal_amplitude);

  // Per-flag live condition; the sine and cosine pairs share one mask and store
  always_comb begin
    live[FLAG_VECTOR]        = vector_low;
    live[FLAG_SINE_ADC]      = sine_adc_over;
    live[FLAG_COSINE_ADC]    = cosine_adc_over;
    live[FLAG_SINE_OFFSET]   = sine_offset_limit;
    live[FLAG_COSINE_OFFSET] = cosine_offset_limit;
    live[FLAG_SINE_GAIN]     = sine_gain_limit;
    live[FLAG_COSINE_GAIN]   = cosine_gain_limit;
    live[FLAG_SPEED]         = speed_fault;
    // A rate or edge-interval change spoils the outputs like a real fault
    live[FLAG_ABZ]           = abz_fault | rate_setting_changed;
    live[FLAG_NONIUS]        = nonius_fault;
    // Source enables, copied to both flags of a pair
    gate[FLAG_VECTOR]        = vector_mask;
    gate[FLAG_SINE_ADC]      = adc_mask;
    gate[FLAG_COSINE_ADC]    = adc_mask;
    gate[FLAG_SINE_OFFSET]   = offset_mask;
    gate[FLAG_COSINE_OFFSET] = offset_mask;
    gate[FLAG_SINE_GAIN]     = gain_mask;
    gate[FLAG_COSINE_GAIN]   = gain_mask;
    gate[FLAG_SPEED]         = speed_mask;
    gate[FLAG_ABZ]           = abz_mask;
    gate[FLAG_NONIUS]        = nonius_mask;
    // Latch enables, copied the same way
    keep[FLAG_VECTOR]        = vector_store;
    keep[FLAG_SINE_ADC]      = adc_store;
    keep[FLAG_COSINE_ADC]    = adc_store;
    keep[FLAG_SINE_OFFSET]   = offset_store;
    keep[FLAG_COSINE_OFFSET] = offset_store;
    keep[FLAG_SINE_GAIN]     = gain_store;
    keep[FLAG_COSINE_GAIN]   = gain_store;
    keep[FLAG_SPEED]         = speed_store;
    keep[FLAG_ABZ]           = abz_store;
    keep[FLAG_NONIUS]        = nonius_store;
  end

  // Flags: live when store clear, sticky when set; a new fault beats the clear
  always_comb begin
    next_flag = flag;
    for (int i = 0; i < NFLAG; i++) begin
      if (gate[i] && live[i]) begin
        next_flag[i] = 1'h1;
      end else if (!keep[i]) begin
        next_flag[i] = 1'h0;
      end else if (counter_reset_command || preset_pulse) begin
        next_flag[i] = 1'h0;
      end else if (!gate[i]) begin
        // Dropping a mask also drops a stored flag, so a disabled source reads clean
        next_flag[i] = 1'h0;
      end
    end
  end

  // Condensed indications from the next flag state, so they line up with the flags
  always_comb begin
    next_any = |next_flag;
    next_stream[STREAM_WARN_BIT]  = next_flag[FLAG_SINE_OFFSET]
                                  | next_flag[FLAG_COSINE_OFFSET]
                                  | next_flag[FLAG_SINE_GAIN]
                                  | next_flag[FLAG_COSINE_GAIN];
    // The square-wave flag has no place in the stream status
    next_stream[STREAM_ERROR_BIT] = next_flag[FLAG_VECTOR]
                                  | next_flag[FLAG_SINE_ADC]
                                  | next_flag[FLAG_COSINE_ADC]
                                  | next_flag[FLAG_SPEED]
                                  | next_flag[FLAG_NONIUS];
    next_hold = next_any & hold_on_fault;
    next_tri  = next_any & tristate_on_fault;
  end

  // Flag register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag <= FLAGS_RESET;
    end else begin
      flag <= next_flag;
    end
  end

  // Indication registers; a config change reaches the outputs one clock late
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stream_status_bits <= '0;
      any_fault          <= 1'h0;
      abz_hold           <= 1'h0;
      abz_tristate       <= 1'h0;
    end else begin
      stream_status_bits <= next_stream;
      any_fault          <= next_any;
      abz_hold           <= next_hold;
      abz_tristate       <= next_tri;
    end
  end

  // Register-fed outputs
  assign vector_flag        = flag[FLAG_VECTOR];
  assign sine_adc_flag      = flag[FLAG_SINE_ADC];
  assign cosine_adc_flag    = flag[FLAG_COSINE_ADC];
  assign sine_offset_flag   = flag[FLAG_SINE_OFFSET];
  assign cosine_offset_flag = flag[FLAG_COSINE_OFFSET];
  assign sine_gain_flag     = flag[FLAG_SINE_GAIN];
  assign cosine_gain_flag   = flag[FLAG_COSINE_GAIN];
  assign speed_flag         = flag[FLAG_SPEED];
  assign abz_flag           = flag[FLAG_ABZ];
  assign nonius_flag        = flag[FLAG_NONIUS];
  assign status_error       = any_fault;
  assign position_error     = any_fault;
  // Open drain: only ever pulls low, so several devices may share the wire
  assign error_pin_n        = 1'h0;
  assign error_pin_n_oe     = any_fault;

endmodule

// >>> testbench/ssem_sensor_model.sv
`timescale 1ns/1ps
// Sensor front end, amplitude given as percent of nominal
module ssem_sensor_model (
  input  wire logic [6:0] pct,
  output logic [15:0]     mag,
  output logic [15:0]     nom
);
  // Round nominal so each percent is an exact ratio
  assign nom = 16'h03E8;
  assign mag = 16'(pct) * 16'h000A;
endmodule

// >>> testbench/ssem_monitor_chk.sv
`timescale 1ns/1ps
// Speed and offset paths stand in for the other sources; the ABZ and nonius paths get checks of their own
module ssem_monitor_chk (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       speed_mask,
  input wire logic       speed_store,
  input wire logic       speed_fault,
  input wire logic       preset_pulse,
  input wire logic       offset_mask,
  input wire logic       sine_offset_limit,
  input wire logic       hold_on_fault,
  input wire logic       tristate_on_fault,
  input wire logic       abz_mask,
  input wire logic       abz_fault,
  input wire logic       rate_setting_changed,
  input wire logic       nonius_mask,
  input wire logic       nonius_fault,
  input wire logic       speed_flag,
  input wire logic       sine_offset_flag,
  input wire logic       abz_flag,
  input wire logic       nonius_flag,
  input wire logic [1:0] stream_status_bits,
  input wire logic       error_pin_n_oe,
  input wire logic       abz_hold,
  input wire logic       abz_tristate
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_set; speed_mask && speed_fault |=> speed_flag; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_msk; !speed_mask |=> !speed_flag; endproperty
  a_msk: assert property (p_msk) else $error("mask");
  property p_live; !speed_store && !speed_fault |=> !speed_flag; endproperty
  a_live: assert property (p_live) else $error("live");
  property p_clr; preset_pulse && !speed_fault |=> !speed_flag; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_off; offset_mask && sine_offset_limit |=> sine_offset_flag; endproperty
  a_off: assert property (p_off) else $error("offset");
  property p_err; speed_flag |-> stream_status_bits[1]; endproperty
  a_err: assert property (p_err) else $error("err bit");
  property p_warn; sine_offset_flag |-> stream_status_bits[0]; endproperty
  a_warn: assert property (p_warn) else $error("warn bit");
  property p_pin; !error_pin_n_oe |-> !speed_flag && !sine_offset_flag; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_hold; hold_on_fault && speed_mask && speed_fault |=> abz_hold; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_tri; !tristate_on_fault |=> !abz_tristate; endproperty
  a_tri: assert property (p_tri) else $error("tristate");
  property p_abz; abz_mask && abz_fault |=> abz_flag && error_pin_n_oe; endproperty
  a_abz: assert property (p_abz) else $error("abz");
  property p_rate; abz_mask && rate_setting_changed |=> abz_flag; endproperty
  a_rate: assert property (p_rate) else $error("rate change");
  property p_non; nonius_mask && nonius_fault |=> nonius_flag && stream_status_bits[1]; endproperty
  a_non: assert property (p_non) else $error("nonius");
endmodule
bind ssem_monitor ssem_monitor_chk u_chk (
  .clock               (clock),
  .rst_b               (rst_b),
  .speed_mask          (speed_mask),
  .speed_store         (speed_store),
  .speed_fault         (speed_fault),
  .preset_pulse        (preset_pulse),
  .offset_mask         (offset_mask),
  .sine_offset_limit   (sine_offset_limit),
  .hold_on_fault       (hold_on_fault),
  .tristate_on_fault   (tristate_on_fault),
  .abz_mask            (abz_mask),
  .abz_fault           (abz_fault),
  .rate_setting_changed(rate_setting_changed),
  .nonius_mask         (nonius_mask),
  .nonius_fault        (nonius_fault),
  .speed_flag          (speed_flag),
  .sine_offset_flag    (sine_offset_flag),
  .abz_flag            (abz_flag),
  .nonius_flag         (nonius_flag),
  .stream_status_bits  (stream_status_bits),
  .error_pin_n_oe      (error_pin_n_oe),
  .abz_hold            (abz_hold),
  .abz_tristate        (abz_tristate)
);

// >>> testbench/sensor_signal_error_monitor_test.sv
`timescale 1ns/1ps
module sensor_signal_error_monitor_test;
  import ssem_pkg::*;
  localparam int FS [10] = '{SRC_VECTOR, SRC_ADC, SRC_ADC, SRC_OFFSET, SRC_OFFSET,
                             SRC_GAIN, SRC_GAIN, SRC_SPEED, SRC_ABZ, SRC_NONIUS};
  logic clock = 0, rst_b = 0, crc = 0, pre = 0, hd = 0, tr = 0;
  logic [6:0] pct = 7'h32, m = 7'h00, s = 7'h00;
  logic [9:0] lv = 10'h000, fl, ef = 10'h000; // Slot 0 of lv is the rate change pulse
  logic [15:0] mag, nom;
  logic [1:0] ssb;
  logic se, pe, pn, oe, ah, at;
  logic [17:0] q[$];
  int n_mismatch = 0, cmp_count = 0;
  always #5 clock = ~clock;
  ssem_sensor_model u_sen (.pct(pct), .mag(mag), .nom(nom));
  ssem_monitor u_dut (.clock(clock), .rst_b(rst_b), .vector_magnitude(mag),
    .nominal_amplitude(nom), .sine_adc_over(lv[1]), .cosine_adc_over(lv[2]),
    .sine_offset_limit(lv[3]), .cosine_offset_limit(lv[4]), .sine_gain_limit(lv[5]),
    .cosine_gain_limit(lv[6]), .speed_fault(lv[7]), .abz_fault(lv[8]), .nonius_fault(lv[9]),
    .rate_setting_changed(lv[0]), .vector_mask(m[0]), .adc_mask(m[1]), .offset_mask(m[2]),
    .gain_mask(m[3]), .speed_mask(m[4]), .abz_mask(m[5]), .nonius_mask(m[6]),
    .vector_store(s[0]), .adc_store(s[1]), .offset_store(s[2]), .gain_store(s[3]),
    .speed_store(s[4]), .abz_store(s[5]), .nonius_store(s[6]), .hold_on_fault(hd),
    .tristate_on_fault(tr), .counter_reset_command(crc), .preset_pulse(pre),
    .vector_flag(fl[0]), .sine_adc_flag(fl[1]), .cosine_adc_flag(fl[2]),
    .sine_offset_flag(fl[3]), .cosine_offset_flag(fl[4]), .sine_gain_flag(fl[5]),
    .cosine_gain_flag(fl[6]), .speed_flag(fl[7]), .abz_flag(fl[8]), .nonius_flag(fl[9]),
    .status_error(se), .position_error(pe), .stream_status_bits(ssb),
    .error_pin_n(pn), .error_pin_n_oe(oe), .abz_hold(ah), .abz_tristate(at));
  // Inputs held two edges; the flag model is idempotent, so that is harmless
  task automatic step(input logic [9:0] l, input logic [6:0] mm, ss, p,
                      input logic c, r, h, t);
    logic [9:0] lw;
    @(posedge clock);
    {lv, m, s, pct, crc, pre, hd, tr} <= {l, mm, ss, p, c, r, h, t};
    lw = {l[9], l[8] | l[0], l[7:1], 1'(p < 7'h1E)};
    for (int i = 0; i < 10; i++)
      ef[i] = mm[FS[i]] & (lw[i] | (ss[FS[i]] & ef[i] & ~(c | r)));
    @(posedge clock);
    q.push_back({ef, |ef, |ef, |{ef[9], ef[7], ef[2:0]}, |ef[6:3], |ef, h & |ef, t & |ef, 1'b0});
  endtask
  task automatic cmp(input logic [17:0] e, a);
    cmp_count++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR outputs expected %h seen %h", e, a);
    end
  endtask
  // Oldest note against settled outputs
  always @(negedge clock) if (q.size() > 0) cmp(q.pop_front(), {fl, se, pe, ssb, oe, ah, at, pn});
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(4162));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    step(10'h000, 7'h7F, 7'h00, 7'h1D, 0, 0, 0, 0);
    step(10'h000, 7'h7F, 7'h00, 7'h1E, 0, 0, 0, 0);
    $display("vector boundary done");
    step(10'h3FF, 7'h7F, 7'h7F, 7'h32, 0, 0, 1, 1);
    step(10'h000, 7'h7F, 7'h7F, 7'h32, 0, 0, 1, 0);
    step(10'h000, 7'h7F, 7'h7F, 7'h32, 1, 0, 0, 1);
    step(10'h2AA, 7'h7F, 7'h7F, 7'h32, 0, 0, 0, 0);
    step(10'h000, 7'h7F, 7'h7F, 7'h32, 0, 1, 0, 0);
    step(10'h100, 7'h7F, 7'h7F, 7'h32, 0, 0, 0, 0);
    step(10'h000, 7'h7F, 7'h7F, 7'h32, 0, 1, 0, 0);
    step(10'h001, 7'h7F, 7'h7F, 7'h32, 0, 0, 0, 0);
    step(10'h000, 7'h7F, 7'h7F, 7'h32, 0, 1, 0, 0);
    step(10'h380, 7'h0F, 7'h7F, 7'h32, 0, 0, 0, 0);
    $display("latch and clear done");
    // Reset in mid-run with every flag but the vector flag set; faults and stores drop with it
    step(10'h3FF, 7'h7F, 7'h7F, 7'h32, 0, 0, 1, 1);
    @(posedge clock);
    {lv, s} <= '0;
    rst_b <= 1'b0;
    ef = 10'h000;
    @(posedge clock);
    q.push_back(18'h00000);
    rst_b <= 1'b1;
    $display("mid-run reset done");
    for (int k = 0; k < 300; k++)
      step(10'($urandom), 7'($urandom), 7'($urandom), 7'($urandom_range(60)),
           $urandom_range(7) == 0, $urandom_range(7) == 0, 1'($urandom), 1'($urandom));
    $display("random mix done");
    // Bounded drain of the last note; a stuck note counts as a mismatch
    for (int w = 0; w < 4 && q.size() > 0; w++)
      @(posedge clock);
    if (q.size() > 0) n_mismatch++;
    final_report();
  end
endmodule
